// >>> sspi_regs.svh
`ifndef SSPI_REGS_SVH
`define SSPI_REGS_SVH
// register offsets on the plain register port (8-bit address)
`define SSPI_OFS_CONTROL   8'h2C
`define SSPI_OFS_STATUS    8'h2D
`define SSPI_OFS_DATA      8'h2E
// control field positions
`define SSPI_CTL_IRQ_EN    7
`define SSPI_CTL_ENABLE    6
`define SSPI_CTL_ORDER     5
`define SSPI_CTL_ROLE      4
`define SSPI_CTL_POL       3
`define SSPI_CTL_PHA       2
`define SSPI_CTL_RATE_HI   1
`define SSPI_CTL_RATE_LO   0
// status field positions
`define SSPI_STA_DONE      7
`define SSPI_STA_WRITE_COLLISION_FLAG      6
`define SSPI_STA_DOUBLE    0
// reset values
`define SSPI_CONTROL_RST   8'h00
`define SSPI_DATA_RST      8'h00
// timing: half serial clock period in system clocks per rate code
`define SSPI_HALF_DIV4     7'd2
`define SSPI_HALF_DIV16    7'd8
`define SSPI_HALF_DIV64    7'd32
`define SSPI_HALF_DIV128   7'd64
`define SSPI_HALF_DIV2     7'd1
`define SSPI_HALF_DIV8     7'd4
`define SSPI_HALF_DIV32    7'd16
`define SSPI_BITS          4'd8
`endif

// >>> sspi_pkg.sv
package sspi_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_LEAD  = 3'b010,
		ST_TRAIL = 3'b100
	} sspi_state_t;
endpackage

// >>> sspi_sync.sv
`timescale 1ns/100ps
`default_nettype none
// three-stage pin synchroniser; a change is taken when stages two and three
// agree, so a single-cycle glitch on stage two never passes
module sspi_sync (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic en_i,
	// pin and clean level
	input  wire logic pin_i,
	output var  logic level_o
);
	logic [2:0] stage;
	logic [2:0] next_stage;
	logic       next_level;

	// shift chain and agreement filter
	always_comb begin
		next_stage = {stage[1:0], pin_i};
		next_level = (stage[1] == stage[2]) ? stage[2] : level_o;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage   <= 3'h7;
			level_o <= 1'b1;
		end else if (en_i) begin
			stage   <= next_stage;
			level_o <= next_level;
		end
	end
endmodule
`default_nettype wire

// >>> sspi_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "sspi_regs.svh"
// Functional notes
// - bit-order one sends least significant bit first, zero most first
// - role-select one means master, zero means slave
// - select pin low as input in master: drop role bit, set done flag
// - polarity one idles clock high, zero idles low
// - phase zero samples leading edge; phase one samples trailing edge
// - shift out and latch in on opposite edges; mode is pol*2+pha
// - master rate codes divide clock by 4, 16, 64, 128
// - rate bits are ignored in slave operation
// - double speed halves divisors to 2, 8, 32, 64
// - shortest master serial clock period is two system clocks
// - done flag sets when a transfer finishes
// - interrupt request while done flag, interrupt enable bit, global enable
// - done flag clears when the interrupt vector is taken
// - status read with done set then data access clears done
// - data write during a transfer sets collision flag
// - status read with collision set then data access clears both
// - status bits five to one read zero
// - data write starts transmission of the byte
// - data read returns the receive buffer
// - no serial operation unless port enable is one
// - slave select high in slave resets logic, drops partial byte
module sspi_port (
	// clock, reset, enable
	input  wire logic       MCLK_I,
	input  wire logic       RESET_N_I,
	input  wire logic       CLK_EN_I,
	// register port
	input  wire logic [7:0] ADDR_I,
	input  wire logic [7:0] WDATA_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	output var  logic [7:0] RDATA_O,
	// interrupt handshake with the core
	input  wire logic       GLOBAL_IRQ_EN_I,
	input  wire logic       IRQ_ACK_I,
	output var  logic       IRQ_O,
	// select pin direction, set by the port's pin configuration
	input  wire logic       SS_IS_INPUT_I,
	// serial pins: clock, master out, master in, select
	input  wire logic       SCK_I,
	output var  logic       SCK_O,
	output var  logic       SCK_OE_O,
	input  wire logic       MOSI_I,
	output var  logic       MOSI_O,
	output var  logic       MOSI_OE_O,
	input  wire logic       MISO_I,
	output var  logic       MISO_O,
	output var  logic       MISO_OE_O,
	input  wire logic       SS_N_I
);
	// synchronised pin levels
	logic sck_s, mosi_s, ss_n_s;

	sspi_sync u_sync_sck (.clk_i(MCLK_I), .rst_n_i(RESET_N_I),
		.en_i(CLK_EN_I), .pin_i(SCK_I), .level_o(sck_s));
	sspi_sync u_sync_mosi (.clk_i(MCLK_I), .rst_n_i(RESET_N_I),
		.en_i(CLK_EN_I), .pin_i(MOSI_I), .level_o(mosi_s));
	// the master reads its reply line directly: that line moves on our own
	// clock edge, and a three-stage delay would miss it at two clocks/bit
	sspi_sync u_sync_ss (.clk_i(MCLK_I), .rst_n_i(RESET_N_I),
		.en_i(CLK_EN_I), .pin_i(SS_N_I), .level_o(ss_n_s));

	// register state
	logic [7:0] control, next_control;
	logic       done, next_done;
	logic       write_collision_flag, next_write_collision_flag;
	logic       dbl, next_dbl;
	logic       armed, next_armed;
	logic [7:0] rx_buf, next_rx_buf;
	logic [7:0] rdata, next_rdata;
	logic       irq, next_irq;
	// shifter state
	sspi_pkg::sspi_state_t state, next_state;
	logic [7:0] shreg, next_shreg;
	logic [3:0] bitcnt, next_bitcnt;
	logic [6:0] divcnt, next_divcnt;
	logic       sck_q, next_sck_q;
	logic       out_bit, next_out_bit;
	logic       sck_prev, next_sck_prev;
	logic       fin;

	// decoded controls
	logic       enable, lsb_first, master, pol, pha;
	logic [6:0] half;
	logic       wr_data, acc_data, rd_stat, mode_fault, busy;
	logic       slave_sel, sck_rise, sck_fall, lead_edge, trail_edge;
	logic       in_bit, first_bit;

	always_comb begin
		enable    = control[`SSPI_CTL_ENABLE];
		lsb_first = control[`SSPI_CTL_ORDER];
		master    = control[`SSPI_CTL_ROLE];
		pol       = control[`SSPI_CTL_POL];
		pha       = control[`SSPI_CTL_PHA];
		wr_data   = WR_I && (ADDR_I == `SSPI_OFS_DATA);
		acc_data  = (WR_I || RD_I) && (ADDR_I == `SSPI_OFS_DATA);
		rd_stat   = RD_I && (ADDR_I == `SSPI_OFS_STATUS);
		busy      = (state != sspi_pkg::ST_IDLE);
		// another master pulls select low while we act as master
		mode_fault = enable && master && SS_IS_INPUT_I && !ss_n_s;
		slave_sel  = enable && !master && !ss_n_s;
		// external clock edges seen through the synchroniser
		sck_rise  = sck_s && !sck_prev;
		sck_fall  = !sck_s && sck_prev;
		lead_edge = pol ? sck_fall : sck_rise;
		trail_edge = pol ? sck_rise : sck_fall;
		in_bit    = master ? MISO_I : mosi_s;
		first_bit = lsb_first ? shreg[0] : shreg[7];
	end

	// half-period select; slave never consults the rate bits
	always_comb begin
		case ({dbl, control[`SSPI_CTL_RATE_HI], control[`SSPI_CTL_RATE_LO]})
		3'b000:  half = `SSPI_HALF_DIV4;
		3'b001:  half = `SSPI_HALF_DIV16;
		3'b010:  half = `SSPI_HALF_DIV64;
		3'b011:  half = `SSPI_HALF_DIV128;
		3'b100:  half = `SSPI_HALF_DIV2;
		3'b101:  half = `SSPI_HALF_DIV8;
		3'b110:  half = `SSPI_HALF_DIV32;
		default: half = `SSPI_HALF_DIV64;
		endcase
	end

	// shift engine: stays in ST_LEAD for the whole byte, ST_TRAIL never entered; eight bits per byte
	always_comb begin
		next_state    = state;
		next_shreg    = shreg;
		next_bitcnt   = bitcnt;
		next_divcnt   = divcnt;
		next_sck_q    = sck_q;
		next_out_bit  = out_bit;
		next_sck_prev = sck_s;
		fin           = 1'b0;
		case (state)
		sspi_pkg::ST_IDLE: begin
			next_sck_q  = pol;
			next_divcnt = 7'd1;
			next_bitcnt = 4'd0;
			// a byte written while unselected waits for the master
			if (wr_data && enable) begin
				next_shreg   = WDATA_I;
				next_out_bit = lsb_first ? WDATA_I[0] : WDATA_I[7];
				if (master || slave_sel) begin
					next_state = sspi_pkg::ST_LEAD;
				end
			end else if (slave_sel && lead_edge) begin
				// external master began without a fresh byte; the first
				// edge already carries a bit, so act on it here
				next_state = sspi_pkg::ST_LEAD;
				if (pha) begin
					next_out_bit = first_bit;
				end else begin
					next_shreg = lsb_first ? {in_bit, shreg[7:1]}
						: {shreg[6:0], in_bit};
				end
			end else if (slave_sel && !pha) begin
				next_out_bit = first_bit;
			end
		end
		sspi_pkg::ST_LEAD, sspi_pkg::ST_TRAIL: begin
			if (master) begin
				// master paces edges from its divider
				if (divcnt == half) begin
					next_divcnt = 7'd1;
					next_sck_q  = !sck_q;
					// leading edge leaves idle level, trailing returns
					if (sck_q == pol) begin
						if (pha) begin
							next_out_bit = first_bit;
						end else begin
							next_shreg = lsb_first ? {in_bit, shreg[7:1]}
								: {shreg[6:0], in_bit};
						end
					end else begin
						next_bitcnt = bitcnt + 4'd1;
						if (pha) begin
							next_shreg = lsb_first ? {in_bit, shreg[7:1]}
								: {shreg[6:0], in_bit};
						end else begin
							next_out_bit = lsb_first ? shreg[0] : shreg[7];
						end
						if (bitcnt == `SSPI_BITS - 4'd1) begin
							fin = 1'b1;
						end
					end
				end else begin
					next_divcnt = divcnt + 7'd1;
				end
			end else begin
				// slave follows the external clock; opposite edges
				if (lead_edge) begin
					if (pha) begin
						next_out_bit = first_bit;
					end else begin
						next_shreg = lsb_first ? {in_bit, shreg[7:1]}
							: {shreg[6:0], in_bit};
					end
				end
				if (trail_edge) begin
					next_bitcnt = bitcnt + 4'd1;
					if (pha) begin
						next_shreg = lsb_first ? {in_bit, shreg[7:1]}
							: {shreg[6:0], in_bit};
					end else begin
						next_out_bit = lsb_first ? shreg[0] : shreg[7];
					end
					if (bitcnt == `SSPI_BITS - 4'd1) begin
						fin = 1'b1;
					end
				end
			end
			if (fin) begin
				next_state = sspi_pkg::ST_IDLE;
				next_sck_q = pol;
			end
			// select released or lost: abandon the byte at once
			if (!enable || mode_fault || (!master && ss_n_s)) begin
				next_state  = sspi_pkg::ST_IDLE;
				next_bitcnt = 4'd0;
				next_sck_q  = pol;
				fin         = 1'b0;
			end
		end
		default: next_state = sspi_pkg::ST_IDLE;
		endcase
	end

	// register file; hardware set wins over any clear in the same cycle
	always_comb begin
		next_control = control;
		next_dbl     = dbl;
		next_done    = done;
		next_write_collision_flag    = write_collision_flag;
		next_armed   = armed;
		next_rx_buf  = fin ? next_shreg : rx_buf;
		next_rdata   = 8'h00;
		if (WR_I && ADDR_I == `SSPI_OFS_CONTROL) begin
			next_control = WDATA_I;
		end
		if (WR_I && ADDR_I == `SSPI_OFS_STATUS) begin
			next_dbl = WDATA_I[`SSPI_STA_DOUBLE];
		end
		if (RD_I) begin
			if (ADDR_I == `SSPI_OFS_CONTROL) begin
				next_rdata = control;
			end else if (ADDR_I == `SSPI_OFS_STATUS) begin
				next_rdata = {done, write_collision_flag, 5'h00, dbl};
			end else if (ADDR_I == `SSPI_OFS_DATA) begin
				next_rdata = rx_buf;
			end
		end
		if (rd_stat && (done || write_collision_flag)) begin
			next_armed = 1'b1;
		end else if (acc_data && armed) begin
			next_armed = 1'b0;
			next_done  = 1'b0;
			next_write_collision_flag  = 1'b0;
		end
		if (IRQ_ACK_I) begin
			next_done = 1'b0;
		end
		if (mode_fault) begin
			next_control[`SSPI_CTL_ROLE] = 1'b0;
		end
		if (fin || mode_fault) begin
			next_done = 1'b1;
		end
		if (wr_data && busy) begin
			next_write_collision_flag = 1'b1;
		end
		next_irq = next_done && next_control[`SSPI_CTL_IRQ_EN]
			&& GLOBAL_IRQ_EN_I;
	end

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			control  <= `SSPI_CONTROL_RST;
			dbl      <= 1'b0;
			done     <= 1'b0;
			write_collision_flag     <= 1'b0;
			armed    <= 1'b0;
			rx_buf   <= `SSPI_DATA_RST;
			rdata    <= 8'h00;
			irq      <= 1'b0;
			state    <= sspi_pkg::ST_IDLE;
			shreg    <= `SSPI_DATA_RST;
			bitcnt   <= 4'd0;
			divcnt   <= 7'd1;
			sck_q    <= 1'b0;
			out_bit  <= 1'b0;
			sck_prev <= 1'b1;
		end else if (CLK_EN_I) begin
			control  <= next_control;
			dbl      <= next_dbl;
			done     <= next_done;
			write_collision_flag     <= next_write_collision_flag;
			armed    <= next_armed;
			rx_buf   <= next_rx_buf;
			rdata    <= next_rdata;
			irq      <= next_irq;
			state    <= next_state;
			shreg    <= next_shreg;
			bitcnt   <= next_bitcnt;
			divcnt   <= next_divcnt;
			sck_q    <= next_sck_q;
			out_bit  <= next_out_bit;
			sck_prev <= next_sck_prev;
		end
	end

	// pin drive registered; master drives clock and data out, slave
	// drives its reply line only while selected
	logic next_sck_oe, next_mosi_oe, next_miso_oe;
	always_comb begin
		next_sck_oe  = next_control[`SSPI_CTL_ENABLE]
			&& next_control[`SSPI_CTL_ROLE];
		next_mosi_oe = next_sck_oe;
		next_miso_oe = next_control[`SSPI_CTL_ENABLE]
			&& !next_control[`SSPI_CTL_ROLE] && !ss_n_s;
	end

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			SCK_O     <= 1'b0;
			SCK_OE_O  <= 1'b0;
			MOSI_O    <= 1'b0;
			MOSI_OE_O <= 1'b0;
			MISO_O    <= 1'b0;
			MISO_OE_O <= 1'b0;
			RDATA_O   <= 8'h00;
			IRQ_O     <= 1'b0;
		end else if (CLK_EN_I) begin
			SCK_O     <= next_sck_q;
			SCK_OE_O  <= next_sck_oe;
			MOSI_O    <= next_out_bit;
			MOSI_OE_O <= next_mosi_oe;
			MISO_O    <= next_out_bit;
			MISO_OE_O <= next_miso_oe;
			RDATA_O   <= next_rdata;
			IRQ_O     <= next_irq;
		end
	end
endmodule
`default_nettype wire

// >>> sspi_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
module sspi_slave_model (
	// serial side
	input  wire logic       sck_i,
	input  wire logic       mosi_i,
	input  wire logic       sel_n_i,
	output var  logic       miso_o,
	// mode and data
	input  wire logic       pol_i,
	input  wire logic       pha_i,
	input  wire logic       lsb_i,
	input  wire logic [7:0] tx_i,
	output var  logic [7:0] rx_o
);
	int o;
	function automatic logic pick(input int k);
		return lsb_i ? tx_i[k] : tx_i[7 - k];
	endfunction
	// known level before the first selection
	initial miso_o = 1'b1;
	// first bit ready before the first edge
	always @(negedge sel_n_i) begin
		o = 0;
		miso_o = pick(0);
	end
	// no pull on the line: released value is the inverse, never stale
	always @(posedge sel_n_i)
		miso_o = ~miso_o;
	// leading edge leaves the idle level; sample and setup never share
	always @(sck_i) begin
		if (!sel_n_i) begin
			if ((sck_i != pol_i) ^ pha_i)
				rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
			else begin
				if (!pha_i)
					o = o + 1;
				if (o < 8)
					miso_o = pick(o);
				if (pha_i)
					o = o + 1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> sspi_port_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "sspi_regs.svh"
module sspi_port_chk (
	// clock and reset
	input  wire logic       MCLK_I,
	input  wire logic       RESET_N_I,
	input  wire logic       CLK_EN_I,
	// register port
	input  wire logic [7:0] ADDR_I,
	input  wire logic [7:0] WDATA_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	input  wire logic [7:0] RDATA_O,
	// interrupt
	input  wire logic       GLOBAL_IRQ_EN_I,
	input  wire logic       IRQ_ACK_I,
	input  wire logic       IRQ_O,
	// pin drive
	input  wire logic       SCK_OE_O,
	input  wire logic       MOSI_OE_O,
	input  wire logic       MISO_OE_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RESET_N_I);
	chk_rdata_idle: assert property ($past(CLK_EN_I && !RD_I)
		|-> RDATA_O == 8'h00) else $error("read data not idle");
	chk_status_resv: assert property ($past(CLK_EN_I && RD_I &&
		ADDR_I == `SSPI_OFS_STATUS) |-> RDATA_O[5:1] == 5'h00)
		else $error("reserved status bits set");
	chk_unmapped_zero: assert property ($past(CLK_EN_I && RD_I &&
		(ADDR_I < `SSPI_OFS_CONTROL || ADDR_I > `SSPI_OFS_DATA))
		|-> RDATA_O == 8'h00) else $error("unmapped read not zero");
	chk_irq_global: assert property (IRQ_O && $past(CLK_EN_I)
		|-> $past(GLOBAL_IRQ_EN_I)) else $error("irq without global");
	chk_ack_clear: assert property (IRQ_ACK_I && CLK_EN_I
		|-> ##2 !IRQ_O) else $error("irq stays after ack");
	chk_role_excl: assert property (SCK_OE_O |-> !MISO_OE_O)
		else $error("master drives slave output");
	chk_master_out: assert property (SCK_OE_O |-> MOSI_OE_O)
		else $error("master data pin not driven");
	chk_ctl_echo: assert property ($past(WR_I && ADDR_I ==
		`SSPI_OFS_CONTROL, 3) && $past(RD_I && ADDR_I ==
		`SSPI_OFS_CONTROL) && $past(CLK_EN_I, 3) |->
		RDATA_O == $past(WDATA_I, 3)) else $error("control echo");
endmodule
bind sspi_port sspi_port_chk u_chk (.MCLK_I(MCLK_I),
	.RESET_N_I(RESET_N_I), .CLK_EN_I(CLK_EN_I), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.GLOBAL_IRQ_EN_I(GLOBAL_IRQ_EN_I), .IRQ_ACK_I(IRQ_ACK_I),
	.IRQ_O(IRQ_O), .SCK_OE_O(SCK_OE_O), .MOSI_OE_O(MOSI_OE_O),
	.MISO_OE_O(MISO_OE_O));
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "sspi_regs.svh"
module tb;
	localparam logic [7:0] CTL = `SSPI_OFS_CONTROL;
	localparam logic [7:0] STA = `SSPI_OFS_STATUS;
	localparam logic [7:0] DAT = `SSPI_OFS_DATA;
	logic       clk, rst_n, wr, rd, gie, ack, ss_in, ss_n, sel_n;
	logic       sck, mosi, miso, irq, pol, pha, lsb, sck_q;
	logic [7:0] addr, wdata, rdata, tx, rx, got;
	logic       esck, emosi, smiso;
	int         n_fail, tests_run, i, tog, gap, gmin, gmax;
	sspi_port DUT (.MCLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(1'b1),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.RDATA_O(rdata), .GLOBAL_IRQ_EN_I(gie), .IRQ_ACK_I(ack),
		.IRQ_O(irq), .SS_IS_INPUT_I(ss_in), .SCK_I(esck), .SCK_O(sck),
		.SCK_OE_O(), .MOSI_I(emosi), .MOSI_O(mosi), .MOSI_OE_O(),
		.MISO_I(miso), .MISO_O(smiso), .MISO_OE_O(), .SS_N_I(ss_n));
	sspi_slave_model partner (.sck_i(sck), .mosi_i(mosi), .sel_n_i(sel_n),
		.miso_o(miso), .pol_i(pol), .pha_i(pha), .lsb_i(lsb), .tx_i(tx),
		.rx_o(rx));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// serial clock edges and spacing in system clocks
	always @(posedge clk) begin
		gap = gap + 1;
		if (sck !== sck_q) begin
			if (tog > 0 && gap < gmin) gmin = gap;
			if (tog > 0 && gap > gmax) gmax = gap;
			tog = tog + 1;
			gap = 0;
		end
		sck_q = sck;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, e, input string m);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	// one idle cycle after each strobe so no signal is set twice per step
	task automatic wr_reg(input logic [7:0] a, d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	task automatic wait_done();
		int k;
		k = 0;
		do begin
			rd_reg(STA, got);
			k++;
		end while (got[7] !== 1'b1 && k < 3000);
		if (k == 3000) begin
			chk(8'h00, 8'h01, "timeout");
			complete_run();
		end
	endtask
	// external master, mode 0, most significant bit first; sixteen system
	// clocks per bit keeps it well under the quarter-rate slave limit
	task automatic ext_byte(input logic [7:0] d, input int n,
		output logic [7:0] r);
		r = 8'h00;
		for (int b = 0; b < n; b++) begin
			emosi <= d[7 - b];
			repeat (8) @(posedge clk);
			esck <= 1'b1;
			r = {r[6:0], smiso};
			repeat (8) @(posedge clk);
			esck <= 1'b0;
		end
		repeat (8) @(posedge clk);
	endtask
	function automatic int half(input logic dbl, input logic [1:0] c);
		int h;
		h = (c == 2'd3) ? 64 : (2 << (2 * c));
		return dbl ? h / 2 : h;
	endfunction
	// m: mode in [1:0], low bit first in [2], double speed in [3]
	task automatic xfer(input logic [3:0] m, input logic col,
		input logic [1:0] rc);
		logic [7:0] d;
		logic       ie;
		d = 8'($urandom);
		ie = 1'($urandom);
		tx = 8'($urandom);
		{pol, pha} = m[1:0];
		lsb = m[2];
		gie <= 1'($urandom);
		wr_reg(STA, {7'h00, m[3]});
		wr_reg(CTL, {ie, 1'b1, m[2], 1'b1, m[1:0], rc});
		repeat (2) @(posedge clk);
		chk({7'h00, sck}, {7'h00, pol}, "idle level");
		sel_n = 1'b0;
		tog = 0;
		gmin = 999;
		gmax = 0;
		wr_reg(DAT, d);
		if (col) wr_reg(DAT, ~d);
		wait_done();
		chk(got, {1'b1, col, 5'h00, m[3]}, "status");
		chk(8'(tog), 8'd16, "edges");
		chk(8'(gmin), 8'(half(m[3], rc)), "half min");
		chk(8'(gmax), 8'(half(m[3], rc)), "half max");
		chk({7'h00, irq}, {7'h00, ie & gie}, "irq");
		if (irq === 1'b1) begin
			ack <= 1'b1;
			@(posedge clk);
			ack <= 1'b0;
			repeat (3) @(posedge clk);
			chk({7'h00, irq}, 8'h00, "ack");
		end
		rd_reg(DAT, got);
		chk(got, tx, "rx byte");
		chk(rx, d, "tx byte");
		rd_reg(STA, got);
		chk(got, {7'h00, m[3]}, "cleared");
		sel_n = 1'b1;
		$display("test mode %0d done", m);
	endtask
	initial begin
		{rst_n, wr, rd, gie, ack, ss_in} = 6'h00;
		{addr, wdata, tx} = 24'h000000;
		{ss_n, sel_n, pol, pha, lsb} = 5'b11000;
		{esck, emosi} = 2'b00;
		{n_fail, tests_run, tog, gap} = 128'h0;
		void'($urandom(32'h0a05));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_reg(CTL, got);
		chk(got, `SSPI_CONTROL_RST, "ctl reset");
		wr_reg(STA, 8'hFF);
		rd_reg(STA, got);
		chk(got, 8'h01, "reserved");
		wr_reg(8'h7F, 8'hFF);
		rd_reg(8'h7F, got);
		chk(got, 8'h00, "unmapped");
		wr_reg(CTL, 8'h2D);
		rd_reg(CTL, got);
		chk(got, 8'h2D, "ctl echo");
		for (i = 0; i < 16; i++)
			xfer(4'(i), 1'(i % 3 == 0), 2'($urandom));
		xfer(4'b1000, 1'b1, 2'b00);
		xfer(4'b0011, 1'b0, 2'b11);
		// select pulled low by another master
		wr_reg(CTL, 8'h50);
		ss_in <= 1'b1;
		ss_n <= 1'b0;
		wait_done();
		rd_reg(CTL, got);
		chk(got, 8'h40, "role dropped");
		ss_n <= 1'b1;
		ss_in <= 1'b0;
		rd_reg(DAT, got);
		$display("test select fault done");
		wr_reg(CTL, 8'h10);
		tog = 0;
		wr_reg(DAT, 8'hA5);
		repeat (200) @(posedge clk);
		rd_reg(STA, got);
		chk({got[7], 7'h00}, 8'h00, "port off");
		chk(8'(tog), 8'h00, "no clock");
		$display("test port off done");
		// slave: rate bits set on purpose, they must not matter
		wr_reg(CTL, 8'h43);
		ss_n <= 1'b0;
		repeat (8) @(posedge clk);
		wr_reg(DAT, 8'h96);
		ext_byte(8'h3C, 8, got);
		chk(got, 8'h96, "slave reply");
		rd_reg(STA, got);
		chk(got, 8'h80, "slave done");
		rd_reg(DAT, got);
		chk(got, 8'h3C, "slave rx");
		ext_byte(8'hFF, 3, got);
		ss_n <= 1'b1;
		repeat (8) @(posedge clk);
		ss_n <= 1'b0;
		repeat (8) @(posedge clk);
		ext_byte(8'h5A, 8, got);
		rd_reg(DAT, got);
		chk(got, 8'h5A, "slave abort");
		ss_n <= 1'b1;
		$display("test slave done");
		complete_run();
	end
endmodule
`default_nettype wire
